/* logic/acs_pkg.sv */
// ==========================================================
// Calibration sequencer constants
package acs_pkg;
   // Register byte addresses.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TRIG = 8'h04;
   localparam logic [7:0] REG_DELAY = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_TRIM0 = 8'h10;
   // Control register bit positions.
   localparam int CTRL_CAL_EN = 0;
   localparam int CTRL_BG = 1;
   localparam int CTRL_FG_OS = 2;
   localparam int CTRL_BG_OS = 3;
   localparam int CTRL_LP = 4;
   localparam int CTRL_LP_SWAP = 5;
   localparam int CTRL_TRIG_SRC = 6;
   localparam int CTRL_SINGLE = 7;
   localparam int CTRL_IN_SEL = 8;
   localparam int CTRL_W = 9;
   // Delay register fields and status positions.
   localparam int DLY_SLEEP_LSB = 0;
   localparam int DLY_SETTLE_LSB = 16;
   localparam int ST_COMPLETE = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_SLOT_A = 2;
   localparam int ST_SLOT_B = 4;
   localparam int ST_SPARE = 6;
   localparam int ST_ASLEEP = 8;
   // Reset values.
   localparam logic [8:0] CTRL_RST = 9'h001;
   localparam logic [15:0] SLEEP_RST = 16'h0100;
   localparam logic [15:0] SETTLE_RST = 16'h0040;
   // Sample width, mid-code and core identities.
   localparam int SAMPLE_W = 12;
   localparam logic [11:0] MID_CODE = 12'h000;
   localparam logic [1:0] CORE_A = 2'h0;
   localparam logic [1:0] CORE_B = 2'h1;
   localparam logic [1:0] CORE_C = 2'h2;
   // Sequencer states, Gray coded from ST_IDLE through ST_SWAP in listed order, but not on the ST_SWAP to ST_SLEEP return.
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_FG = 3'h1,
      ST_FG_OFS = 3'h3,
      ST_SLEEP = 3'h2,
      ST_WAKE = 3'h6,
      ST_BG_CAL = 3'h7,
      ST_SWAP = 3'h5
   } acs_state_t;
endpackage : acs_pkg

/* logic/acs_sequencer.sv */
`timescale 1ns/10ps
// ==========================================================
// Calibration sequencer for a three-core interleaved converter
// Overview of operation
// R1 - Foreground or background calibration, each with optional offset step.
// R2 - Foreground calibration forces every output sample to mid-code zero.
// R3 - Three two-bank cores: A, B and spare C.
// R4 - Foreground: A takes input A, B input B; single channel shares one.
// R5 - Background: spare core C periodically substitutes for core A or B.
// R6 - Calibrated spare takes over; released core becomes next spare.
// R7 - Foreground calibration runs at power-up; host waits before writing.
// R8 - Trigger comes from pin or software bit, chosen by source select.
// R9 - Host enables background: background on, source select 0, soft bit 1.
// R10 - Low-power background keeps offline spare powered down until due.
// R11 - Sleep delay sets spare sleep time when automatic swapping.
// R12 - Settle delay sets how long a woken spare settles before calibrating.
// R13 - Swap select picks automatic swapping or swapping on trigger.
// R14 - Host avoids low-power background with single-channel operation.
// R15 - Foreground offset enable runs input offset calibration once.
// R16 - Background offset enable recalculates offset each background pass.
// R17 - Host sets foreground offset enable before calibration enable.
// R18 - Offset results land in trim registers; host writes then blocked.
// R19 - Host reads trims only after completion, never in background offset.
// R20 - Trims start at factory values and stay readable and writable.
// R21 - Rising edge of selected trigger starts; completion flag set at end.
module acs_sequencer
   import acs_pkg::*;
#(
   parameter logic [11:0] TRIM_A_INIT = 12'h800,
   parameter logic [11:0] TRIM_B_INIT = 12'h800,
   parameter logic [11:0] TRIM_C_INIT = 12'h800
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic resetn,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // External trigger pin.
   input wire logic calibration_trigger_pin,
   // Core samples and channel outputs.
   input wire logic [11:0] core_sample_a,
   input wire logic [11:0] core_sample_b,
   input wire logic [11:0] core_sample_c,
   output logic [11:0] chan_a_data,
   output logic [11:0] chan_b_data,
   // Core routing and power.
   output logic [2:0] core_input_b,
   output logic [2:0] core_power_on,
   // Calibration engine handshake.
   output logic cal_req,
   output logic [2:0] cal_core_mask,
   output logic cal_offset,
   input wire logic cal_ack,
   input wire logic [11:0] ofs_result_a,
   input wire logic [11:0] ofs_result_b,
   input wire logic [11:0] ofs_result_c
);
   // ==========================================================
   // Registers and state
   logic [8:0] ctrl, next_ctrl;
   logic soft_trig, next_soft_trig;
   logic [15:0] sleep_dly, next_sleep_dly;
   logic [15:0] settle_dly, next_settle_dly;
   logic [31:0] next_rdata;
   logic fg_complete, next_fg_complete;
   acs_state_t state, next_state;
   logic [15:0] timer, next_timer;
   logic [1:0] slot_a, slot_b, spare;
   logic [1:0] next_slot_a, next_slot_b, next_spare;
   logic swap_b, next_swap_b;
   logic trig_q, trig_src, trig_edge;
   logic [11:0] trim [3];
   logic [11:0] ofs_res [3];
   logic [11:0] sample [3];
   logic [11:0] next_chan_a, next_chan_b;
   logic fg_active, ofs_in_use, spare_asleep, ofs_ack;

   assign ofs_res[0] = ofs_result_a;
   assign ofs_res[1] = ofs_result_b;
   assign ofs_res[2] = ofs_result_c;
   assign sample[0] = core_sample_a;
   assign sample[1] = core_sample_b;
   assign sample[2] = core_sample_c;
   assign fg_active = (state == ST_FG) || (state == ST_FG_OFS);
   assign ofs_in_use = ctrl[CTRL_FG_OS] | ctrl[CTRL_BG_OS];
   assign ofs_ack = cal_ack & cal_offset;

   // ==========================================================
   // Trigger selection and edge detection
   // Select pin or software bit, then catch the rising edge.
   assign trig_src = ctrl[CTRL_TRIG_SRC] ? calibration_trigger_pin
                                         : soft_trig; // [R8]
   assign trig_edge = trig_src & ~trig_q; // [R21]

   // Remember the previous trigger level.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         trig_q <= 1'b0;
      end else begin
         trig_q <= trig_src;
      end
   end

   // ==========================================================
   // Register file
   // Decode writes and build the read word.
   always_comb begin
      next_ctrl = ctrl;
      next_soft_trig = soft_trig;
      next_sleep_dly = sleep_dly;
      next_settle_dly = settle_dly;
      next_rdata = 32'h0000_0000;
      if (reg_wr) begin
         case (reg_addr)
            REG_CTRL: next_ctrl = reg_wdata[CTRL_W-1:0];
            REG_TRIG: next_soft_trig = reg_wdata[0];
            REG_DELAY: begin
               next_sleep_dly = reg_wdata[DLY_SLEEP_LSB +: 16]; // [R11]
               next_settle_dly = reg_wdata[DLY_SETTLE_LSB +: 16]; // [R12]
            end
            default: next_ctrl = ctrl;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: next_rdata[CTRL_W-1:0] = ctrl;
            REG_TRIG: next_rdata[0] = soft_trig;
            REG_DELAY: begin
               next_rdata[DLY_SLEEP_LSB +: 16] = sleep_dly;
               next_rdata[DLY_SETTLE_LSB +: 16] = settle_dly;
            end
            REG_STATUS: begin
               next_rdata[ST_COMPLETE] = fg_complete;
               next_rdata[ST_BUSY] = (state != ST_IDLE);
               next_rdata[ST_SLOT_A +: 2] = slot_a;
               next_rdata[ST_SLOT_B +: 2] = slot_b;
               next_rdata[ST_SPARE +: 2] = spare;
               next_rdata[ST_ASLEEP] = spare_asleep;
            end
            REG_TRIM0: next_rdata[11:0] = trim[0]; // [R20]
            REG_TRIM0 + 8'h04: next_rdata[11:0] = trim[1];
            REG_TRIM0 + 8'h08: next_rdata[11:0] = trim[2];
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Register the configuration and read data.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ctrl <= CTRL_RST;
         soft_trig <= 1'b0;
         sleep_dly <= SLEEP_RST;
         settle_dly <= SETTLE_RST;
         reg_rdata <= 32'h0000_0000;
      end else begin
         ctrl <= next_ctrl;
         soft_trig <= next_soft_trig;
         sleep_dly <= next_sleep_dly;
         settle_dly <= next_settle_dly;
         reg_rdata <= next_rdata;
      end
   end

   // ==========================================================
   // Input offset trims, one per core
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_trim
         localparam logic [11:0] INIT = (gi == 0) ? TRIM_A_INIT :
                                        (gi == 1) ? TRIM_B_INIT :
                                                    TRIM_C_INIT;
         localparam logic [7:0] ADDR = REG_TRIM0 + 8'(4 * gi);
         logic [11:0] next_trim;
         // Offset results win; host writes only while offset is unused.
         always_comb begin
            next_trim = trim[gi];
            if (ofs_ack && cal_core_mask[gi]) begin
               next_trim = ofs_res[gi]; // [R18]
            end else if (reg_wr && reg_addr == ADDR && !ofs_in_use) begin
               next_trim = reg_wdata[11:0]; // [R20]
            end
         end
         // Trims come up at their factory values.
         always_ff @(posedge mclk) begin
            if (!resetn) begin
               trim[gi] <= INIT; // [R20]
            end else begin
               trim[gi] <= next_trim;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Calibration sequence
   // Step through foreground, offset and background rotation.
   always_comb begin
      next_state = state;
      next_timer = timer + 16'h0001;
      next_fg_complete = fg_complete;
      next_slot_a = slot_a;
      next_slot_b = slot_b;
      next_spare = spare;
      next_swap_b = swap_b;
      case (state)
         ST_IDLE: begin
            if (trig_edge && ctrl[CTRL_CAL_EN]) begin
               next_state = ST_FG; // [R21]
               next_fg_complete = 1'b0;
            end
         end
         ST_FG: begin
            if (cal_ack) begin
               if (ctrl[CTRL_FG_OS]) begin
                  next_state = ST_FG_OFS; // [R15]
               end else begin
                  next_state = ctrl[CTRL_BG] ? ST_SLEEP : ST_IDLE; // [R1]
                  next_fg_complete = 1'b1; // [R21]
               end
            end
         end
         ST_FG_OFS: begin
            if (cal_ack) begin
               next_state = ctrl[CTRL_BG] ? ST_SLEEP : ST_IDLE; // [R15]
               next_fg_complete = 1'b1;
            end
         end
         ST_SLEEP: begin
            if (!ctrl[CTRL_BG]) begin
               next_state = ST_IDLE;
            end else if (!ctrl[CTRL_LP]) begin
               next_state = ST_BG_CAL; // [R5]
            end else if (ctrl[CTRL_LP_SWAP] ? trig_edge
                                            : (timer >= sleep_dly)) begin
               next_state = ST_WAKE; // [R13] [R11]
            end
         end
         ST_WAKE: begin
            if (timer >= settle_dly) begin
               next_state = ST_BG_CAL; // [R12]
            end
         end
         ST_BG_CAL: begin
            if (cal_ack) begin
               next_state = ST_SWAP;
            end
         end
         ST_SWAP: begin
            // Spare replaces one slot; released core becomes the spare.
            if (swap_b) begin
               next_slot_b = spare; // [R6]
               next_spare = slot_b;
            end else begin
               next_slot_a = spare; // [R6]
               next_spare = slot_a;
            end
            next_swap_b = ~swap_b;
            next_state = ST_SLEEP;
         end
         default: next_state = ST_IDLE;
      endcase
      if (next_state != state) begin
         next_timer = 16'h0000;
      end
   end

   // Register the sequencer; reset starts a foreground pass.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state <= ST_FG; // [R7]
         timer <= 16'h0000;
         fg_complete <= 1'b0;
         slot_a <= CORE_A; // [R3]
         slot_b <= CORE_B;
         spare <= CORE_C;
         swap_b <= 1'b0;
      end else begin
         state <= next_state;
         timer <= next_timer;
         fg_complete <= next_fg_complete;
         slot_a <= next_slot_a;
         slot_b <= next_slot_b;
         spare <= next_spare;
         swap_b <= next_swap_b;
      end
   end

   // ==========================================================
   // Engine requests, routing and power
   // Foreground works on both active slots, background on the spare.
   assign cal_req = fg_active || (state == ST_BG_CAL);
   assign cal_offset = (state == ST_FG_OFS) ||
                       ((state == ST_BG_CAL) && ctrl[CTRL_BG_OS]); // [R16]
   assign spare_asleep = ctrl[CTRL_LP] && (state == ST_SLEEP); // [R10]
   generate
      for (gi = 0; gi < 3; gi++) begin : g_core
         logic is_a, is_b;
         assign is_a = (slot_a == 2'(gi));
         assign is_b = (slot_b == 2'(gi));
         assign cal_core_mask[gi] = fg_active ? (is_a | is_b)
                                              : (spare == 2'(gi));
         // Single channel shares the chosen input across cores.
         assign core_input_b[gi] = ctrl[CTRL_SINGLE] ? ctrl[CTRL_IN_SEL] :
                                   is_a ? 1'b0 : is_b ? 1'b1 :
                                   swap_b; // [R4]
         assign core_power_on[gi] = !(spare_asleep && spare == 2'(gi));
      end
   endgenerate

   // ==========================================================
   // Output data
   // Hold mid-code during foreground, else pass the slot cores.
   always_comb begin
      next_chan_a = fg_active ? MID_CODE : sample[slot_a]; // [R2]
      next_chan_b = fg_active ? MID_CODE : sample[slot_b]; // [R2]
   end

   // Register the channel outputs.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         chan_a_data <= MID_CODE;
         chan_b_data <= MID_CODE;
      end else begin
         chan_a_data <= next_chan_a;
         chan_b_data <= next_chan_b;
      end
   end

   // ==========================================================
   // Checks
   chk_mid_code_out: assert property (@(posedge mclk) disable iff (!resetn)
      fg_active |=> chan_a_data == MID_CODE && chan_b_data == MID_CODE)
      else $error("output not mid-code in foreground"); // [R2]
   chk_power_up_fg: assert property (@(posedge mclk)
      !resetn ##1 resetn |-> state == ST_FG)
      else $error("no foreground pass after reset"); // [R7]
   chk_trigger_start: assert property (@(posedge mclk) disable iff (!resetn)
      state == ST_IDLE && trig_edge && ctrl[CTRL_CAL_EN]
      |=> state == ST_FG && !fg_complete)
      else $error("trigger edge did not start calibration"); // [R21]
   chk_foreground_complete_flag: assert property (@(posedge mclk) disable iff (!resetn)
      state == ST_FG && cal_ack && !ctrl[CTRL_FG_OS] |=> fg_complete)
      else $error("completion flag not set"); // [R21]
   chk_offset_once: assert property (@(posedge mclk) disable iff (!resetn)
      state == ST_FG_OFS && cal_ack |=> !fg_active ##1 state != ST_FG_OFS)
      else $error("offset step repeated"); // [R15]
   chk_spare_sleeps: assert property (@(posedge mclk) disable iff (!resetn)
      state == ST_SLEEP && ctrl[CTRL_LP] |-> !core_power_on[spare])
      else $error("sleeping spare is powered"); // [R10]
   chk_swap_rotate: assert property (@(posedge mclk) disable iff (!resetn)
      state == ST_SWAP |=> ($past(swap_b) ? spare == $past(slot_b)
                                          : spare == $past(slot_a)))
      else $error("released core not made spare"); // [R6]
   chk_trim_locked: assert property (@(posedge mclk) disable iff (!resetn)
      reg_wr && reg_addr == REG_TRIM0 && ofs_in_use && !ofs_ack
      |=> $stable(trim[0]))
      else $error("trim written while offset in use"); // [R18]
   chk_settle_wait: assert property (@(posedge mclk) disable iff (!resetn)
      state == ST_WAKE && timer < settle_dly |=> state == ST_WAKE)
      else $error("spare left settle early"); // [R12]
   chk_bg_offset: assert property (@(posedge mclk) disable iff (!resetn)
      state == ST_BG_CAL |-> cal_offset == ctrl[CTRL_BG_OS])
      else $error("background offset request wrong"); // [R16]
endmodule : acs_sequencer

/* bench/acs_engine_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Behavioural calibration engine facing the sequencer
module acs_engine_model #(
   parameter logic [11:0] OFS_A = 12'h0a1,
   parameter logic [11:0] OFS_B = 12'h0b2,
   parameter logic [11:0] OFS_C = 12'h0c3
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic resetn,
   // Request and chosen response delay.
   input wire logic cal_req,
   input wire logic [7:0] ack_delay,
   // Completion and offset results.
   output logic cal_ack,
   output logic [11:0] ofs_result_a,
   output logic [11:0] ofs_result_b,
   output logic [11:0] ofs_result_c
);
   logic [7:0] count;
   // One acknowledge per request, ack_delay plus one cycles after the request rises.
   always @(posedge mclk) begin
      if (!resetn || !cal_req || cal_ack) begin
         count <= 8'h00;
         cal_ack <= 1'b0;
      end else if (count == ack_delay) begin
         cal_ack <= 1'b1;
      end else begin
         count <= count + 8'h01;
      end
   end
   // Results are valid only with the acknowledge, inverted otherwise.
   assign ofs_result_a = cal_ack ? OFS_A : ~OFS_A;
   assign ofs_result_b = cal_ack ? OFS_B : ~OFS_B;
   assign ofs_result_c = cal_ack ? OFS_C : ~OFS_C;
endmodule : acs_engine_model

/* bench/test_acs_sequencer.sv */
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the calibration sequencer
module test_acs_sequencer;
   import acs_pkg::*;
   localparam logic [11:0] TA = 12'h7a1;
   localparam logic [11:0] TB = 12'h6b2;
   localparam logic [11:0] TC = 12'h5c3;
   logic mclk, resetn, reg_wr, reg_rd, trig_pin, cal_req, cal_offset;
   logic cal_ack;
   logic [7:0] reg_addr, ack_dly;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [11:0] samp_a, samp_b, samp_c, chan_a, chan_b;
   logic [11:0] ofs_a, ofs_b, ofs_c;
   logic [2:0] core_input_b, core_power_on, cal_core_mask;
   int failures = 0, n_checks = 0, n_ofs = 0, n, n0;
   // ==========================================================
   // Design and engine model
   acs_sequencer #(.TRIM_A_INIT(TA), .TRIM_B_INIT(TB),
      .TRIM_C_INIT(TC)) i_acs_sequencer (.mclk(mclk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .calibration_trigger_pin(trig_pin), .core_sample_a(samp_a),
      .core_sample_b(samp_b), .core_sample_c(samp_c),
      .chan_a_data(chan_a), .chan_b_data(chan_b),
      .core_input_b(core_input_b), .core_power_on(core_power_on),
      .cal_req(cal_req), .cal_core_mask(cal_core_mask),
      .cal_offset(cal_offset), .cal_ack(cal_ack), .ofs_result_a(ofs_a),
      .ofs_result_b(ofs_b), .ofs_result_c(ofs_c));
   acs_engine_model i_acs_engine_model (.mclk(mclk), .resetn(resetn),
      .cal_req(cal_req), .ack_delay(ack_dly), .cal_ack(cal_ack),
      .ofs_result_a(ofs_a), .ofs_result_b(ofs_b), .ofs_result_c(ofs_c));
   // Clock of 50 ns period.
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Count acknowledged offset requests.
   always @(posedge mclk) begin
      if (cal_req === 1'b1 && cal_ack === 1'b1 && cal_offset === 1'b1) begin
         n_ofs <= n_ofs + 1;
      end
   end
   // ==========================================================
   // Access and compare tasks
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask : rd
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk("register", e, rv);
   endtask : rdchk
   task automatic wait_req(input logic lvl, input int maxc);
      n = 0;
      while (cal_req !== lvl && n < maxc) begin
         @(posedge mclk);
         #1 n++;
      end
      chk("cal_req", 32'(lvl), 32'(cal_req));
   endtask : wait_req
   task automatic wait_done;
      rd(REG_STATUS);
      for (int i = 0; i < 80 && rv[ST_COMPLETE] !== 1'b1; i++) rd(REG_STATUS);
      chk("foreground_complete", 1, 32'(rv[ST_COMPLETE]));
   endtask : wait_done
   task automatic soft_trig(input int maxc);
      wr(REG_TRIG, 0);
      wr(REG_TRIG, 1);
      wait_req(1'b1, maxc);
   endtask : soft_trig
   task automatic do_reset;
      resetn <= 1'b0;
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      #1;
   endtask : do_reset
   task automatic test_done;
      if (failures == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   // Watchdog well beyond the expected run length.
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      test_done();
   end
   // ==========================================================
   // Test sequence
   initial begin
      {resetn, reg_wr, reg_rd, trig_pin, reg_addr, reg_wdata} = '0;
      samp_a = 12'h123;
      samp_b = 12'h456;
      samp_c = 12'h789;
      ack_dly = 8'd20;
      do_reset();
      chk("power-up cal", 1, 32'(cal_req));
      chk("chan a", 0, 32'(chan_a));
      chk("chan b", 0, 32'(chan_b));
      wait_done();
      repeat (3) @(posedge mclk);
      #1 chk("chan a", 32'(samp_a), 32'(chan_a));
      chk("chan b", 32'(samp_b), 32'(chan_b));
      chk("routing", 2, 32'(core_input_b[1:0]));
      rdchk(REG_CTRL, 32'(CTRL_RST));
      rdchk(REG_DELAY, {SETTLE_RST, SLEEP_RST});
      rdchk(REG_TRIM0, 32'(TA));
      rdchk(REG_TRIM0 + 8'h08, 32'(TC));
      rdchk(8'h40, 0);
      wr(REG_TRIM0 + 8'h04, 32'h5a5);
      rdchk(REG_TRIM0 + 8'h04, 32'h5a5);
      wr(REG_CTRL, 32'h181);
      #1 chk("single b", 3, 32'(core_input_b[1:0]));
      wr(REG_CTRL, 32'h081);
      #1 chk("single a", 0, 32'(core_input_b[1:0]));
      // Foreground pass with one offset step, enable set first.
      wr(REG_CTRL, 32'h004);
      wr(REG_CTRL, 32'h005);
      n0 = n_ofs;
      soft_trig(10);
      @(posedge mclk);
      #1 chk("fg mid-code", 0, 32'({chan_a, chan_b}));
      wait_done();
      chk("offset passes", 1, 32'(n_ofs - n0));
      rdchk(REG_TRIM0, 32'h0a1);
      rdchk(REG_TRIM0 + 8'h04, 32'h0b2);
      wr(REG_TRIM0, 32'h3c3);
      rdchk(REG_TRIM0, 32'h0a1);
      // Pin source: software bit ignored, pin edge starts.
      wr(REG_CTRL, 32'h041);
      wr(REG_TRIG, 0);
      wr(REG_TRIG, 1);
      repeat (5) @(posedge mclk);
      #1 chk("soft ignored", 0, 32'(cal_req));
      @(posedge mclk);
      trig_pin <= 1'b1;
      wait_req(1'b1, 10);
      wait_done();
      @(posedge mclk);
      trig_pin <= 1'b0;
      // Park the software bit low so the source switch makes no edge.
      wr(REG_TRIG, 0);
      // Background rotation with offset tracking.
      wr(REG_CTRL, 32'h00b);
      soft_trig(10);
      wait_req(1'b0, 60);
      wait_req(1'b1, 20);
      chk("spare c", 4, 32'(cal_core_mask));
      chk("spare route", 2, 32'(core_input_b));
      chk("bg offset", 1, 32'(cal_offset));
      chk("no outage", 32'(samp_a), 32'(chan_a));
      wait_req(1'b0, 60);
      rd(REG_STATUS);
      chk("rotation 1", 32'h06, 32'(rv[7:2]));
      wait_req(1'b1, 20);
      chk("spare a", 1, 32'(cal_core_mask));
      wait_req(1'b0, 60);
      repeat (3) @(posedge mclk);
      rd(REG_STATUS);
      chk("rotation 2", 32'h12, 32'(rv[7:2]));
      chk("core a in b", 32'(samp_a), 32'(chan_b));
      // Low-power automatic swap, dual channel only.
      ack_dly = 8'd3;
      do_reset();
      wait_done();
      wr(REG_DELAY, {16'd10, 16'd30});
      wr(REG_CTRL, 32'h013);
      soft_trig(10);
      wait_done();
      n = 0;
      while (core_power_on[2] === 1'b0 && n < 200) begin
         @(posedge mclk);
         #1 n++;
      end
      chk("sleep span", 1, 32'(n >= 24 && n <= 32));
      n0 = n;
      wait_req(1'b1, 200);
      chk("settle span", 1, 32'(n >= 9 && n <= 12));
      // Low-power swap on trigger: sleeps until the trigger edge.
      do_reset();
      wait_done();
      wr(REG_DELAY, {16'd10, 16'd30});
      wr(REG_CTRL, 32'h033);
      soft_trig(10);
      wait_done();
      repeat (100) @(posedge mclk);
      #1 chk("still asleep", 0, 32'({core_power_on[2], cal_req}));
      soft_trig(25);
      test_done();
   end
endmodule : test_acs_sequencer
